// ### src/eep_pkg.sv
/*
  Package for the serial EEPROM command, status and protect logic:
  opcodes, status field positions, reset values, timing and protect decode.
  Assumes a 10 MHz core clock and an SPI link in mode 0 or 3.
*/
package eep_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARRAY_RD = 8'h03;
  localparam logic [7:0] OP_ARRAY_WR = 8'h02;

  // ----------------------------------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_LOCK = 7;
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_BUSY = 1'b0;
  localparam logic [1:0] RST_BP = 2'h0;
  localparam logic RST_LOCK = 1'b0;

  // ----------------------------------------------------------------
  // Array and frame geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam logic [2:0] CNT_OP = 3'h1;
  localparam logic [2:0] CNT_STAT_WR = 3'h2;
  localparam logic [2:0] CNT_ADDR_DONE = 3'h3;
  localparam logic [2:0] CNT_ARRAY_WR = 3'h4;
  localparam logic [ADDR_W-1:0] BASE_QUARTER = 15'h6000;
  localparam logic [ADDR_W-1:0] BASE_HALF = 15'h4000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 10000;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES = (PROG_TIME_US * CORE_CLK_KHZ + 999) / 1000;
  localparam int TMR_W = 20;

  function automatic logic eep_prot_hit(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (bp)
      2'h1: hit = (a >= BASE_QUARTER);
      2'h2: hit = (a >= BASE_HALF);
      2'h3: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : eep_prot_hit

endpackage : eep_pkg

// ### src/eep_link.sv
/*
  Serial link end of the EEPROM: shifts opcode, address and data in on
  rising sclk, shifts status or array data out on falling sclk.
  Assumes cs_n high between frames; frame results stay frozen after
  deselect until the next frame's first sclk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module eep_link
  import eep_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [7:0] status,
  input wire logic [7:0] array_rdata,
  output logic miso,
  output logic miso_oe_n,
  output logic [ADDR_W-1:0] array_addr,
  output logic [7:0] op,
  output logic [ADDR_W-1:0] waddr,
  output logic [7:0] wdata,
  output logic [2:0] nbytes,
  output logic on_bound
);

  logic [2:0] bitcnt;
  logic [6:0] shreg;
  logic [7:0] st_s1;
  logic [7:0] st_s2;
  logic [7:0] addr_hi;
  logic read_ok;
  logic [7:0] txbuf;
  logic [7:0] next_byte;
  logic fresh;

  assign next_byte = {shreg, mosi};

  // ----------------------------------------------------------------
  // Status crossing, refreshed on every rising sclk edge of a frame
  // ----------------------------------------------------------------
  always_ff @(posedge sclk)
  begin
    st_s1 <= status;
    st_s2 <= st_s1;
  end

  // ----------------------------------------------------------------
  // Input shifter, cleared by deselect
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bitcnt <= 3'h0;
      shreg <= 7'h00;
      fresh <= 1'b1;
    end
    else
    begin
      bitcnt <= bitcnt + 3'h1;
      shreg <= next_byte[6:0];
      fresh <= 1'b0;
    end
  end

  // Byte count survives deselect, so the core can still judge the frame
  always_ff @(posedge sclk)
  begin
    if (fresh)
    begin
      nbytes <= 3'h0;
    end
    else if (bitcnt == 3'h7 && nbytes != CNT_ARRAY_WR)
    begin
      nbytes <= nbytes + 3'h1;
    end
  end

  // Frame results hold over the deselect for the core to pick up
  always_ff @(posedge sclk)
  begin
    on_bound <= (bitcnt == 3'h7);
    if (bitcnt == 3'h7)
    begin
      case (nbytes)
        3'h0: op <= next_byte;
        3'h1:
        begin
          addr_hi <= next_byte;
          wdata <= next_byte;
        end
        3'h2: waddr <= {addr_hi[6:0], next_byte};
        3'h3: wdata <= next_byte;
        default: wdata <= wdata;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read address: load, then step after every byte
  // ----------------------------------------------------------------
  always_ff @(posedge sclk)
  begin
    if (!cs_n && bitcnt == 3'h7 && nbytes == CNT_STAT_WR)
    begin
      array_addr <= {addr_hi[6:0], next_byte};
    end
    else if (!cs_n && bitcnt == 3'h7 && nbytes >= CNT_ADDR_DONE)
    begin
      array_addr <= array_addr + 15'h0001;
    end
  end

  // Read refused when a write cycle runs at opcode time
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      read_ok <= 1'b0;
    end
    else if (bitcnt == 3'h7 && nbytes == 3'h0)
    begin
      read_ok <= (next_byte == OP_ARRAY_RD) && !st_s2[ST_BUSY];
    end
  end

  // ----------------------------------------------------------------
  // Output shifter on falling sclk; released at once by deselect
  // ----------------------------------------------------------------
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
      txbuf <= 8'h00;
    end
    else if (bitcnt == 3'h0 && nbytes != 3'h0)
    begin
      if (op == OP_STAT_RD)
      begin
        // Status repeats for as long as the master keeps clocking
        txbuf <= {st_s2[6:0], 1'b0};
        miso <= st_s2[7];
        miso_oe_n <= 1'b0;
      end
      else if (read_ok && nbytes >= CNT_ADDR_DONE)
      begin
        txbuf <= {array_rdata[6:0], 1'b0};
        miso <= array_rdata[7];
        miso_oe_n <= 1'b0;
      end
      else
      begin
        // Unknown opcodes leave the output released
        miso_oe_n <= 1'b1;
      end
    end
    else
    begin
      miso <= txbuf[7];
      txbuf <= {txbuf[6:0], 1'b0};
    end
  end

endmodule : eep_link

`default_nettype wire

// ### src/eep_cmd.sv
/*
  Command interpreter, status register and write protection of a serial
  EEPROM. Acts on each deselect that the core clock sees.
  Assumes cs_n stays high for at least four core clocks between frames,
  and an array that answers array_rdata combinationally from array_addr.
*/
// Function
// - Latch must be set before any write
// - Latch set only at deselect after opcode
// - Clear opcode then deselect clears latch
// - Latch cleared on reset, clear, write completion
// - Status read accepted at any time
// - Status byte repeats while selected
// - Busy flag high only during write cycle
// - Latch low rejects all write commands
// - Protect bits block writes to selected area
// - Lock and pin low reject status write
// - Status write ends exactly after data byte
// - Valid status write starts timed cycle
// - Busy held, latch cleared at cycle end
// - New protect bits visible after cycle end
// - Unused status bits unchanged, b6-b4 zero
// - Lock low ignores pin; high needs pin
// - Hard lock follows pin and lock, any order
// - Address loaded, addressed byte shifted out
// - Address steps each byte while selected
// - Read address wraps to zero at top
// - Deselect ends read; busy refuses read
// - Opcodes for set, clear, status read
// - Status write, read opcodes; unknown ignored
// - Protect encoding quarter, half, whole array
// - Only fifteen address bits are used
`timescale 1ns/1ps
`default_nettype none

module eep_cmd
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic [7:0] array_rdata,
  output logic miso,
  output logic miso_oe_n,
  output logic [ADDR_W-1:0] array_addr,
  output logic wr_go,
  output logic [ADDR_W-1:0] wr_addr,
  output logic hard_lock_mode,
  output logic soft_guard_mode
);

  logic [7:0] op;
  logic [ADDR_W-1:0] waddr;
  logic [7:0] wdata;
  logic [2:0] nbytes;
  logic on_bound;
  logic [7:0] status_register;
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic wp_s1;
  logic wp_s2;
  logic cs_rise;
  logic write_enable_latch;
  logic write_busy_flag;
  logic protect_sel_hi;
  logic protect_sel_lo;
  logic status_lock_bit;
  logic cyc_is_stat;
  logic [7:0] pend_stat;
  logic [TMR_W-1:0] tmr;
  logic start_stat;
  logic start_arr;
  logic cyc_done;
  logic hard_now;
  logic [TMR_W-1:0] busy_len;

  // ----------------------------------------------------------------
  // Link end on the serial clock
  // ----------------------------------------------------------------
  eep_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .status(status_register),
    .array_rdata(array_rdata),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .array_addr(array_addr),
    .op(op),
    .waddr(waddr),
    .wdata(wdata),
    .nbytes(nbytes),
    .on_bound(on_bound)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers and deselect detect
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end
    else
    begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
    end
  end

  // Frame results are frozen by now, sclk having stopped with the frame
  assign cs_rise = cs_s2 && !cs_d;

  // Bits b6-b4 are tied low
  assign status_register = {status_lock_bit, 3'h0, protect_sel_hi, protect_sel_lo,
                            write_enable_latch, write_busy_flag};

  // Live mode: entered in either order, left by the pin going high or the lock bit clearing
  assign hard_now = status_lock_bit && !wp_s2;

  // ----------------------------------------------------------------
  // Command acceptance at deselect
  // ----------------------------------------------------------------
  // Status write: exactly two whole bytes, latch set, idle, not hard locked
  assign start_stat = cs_rise && op == OP_STAT_WR && nbytes == CNT_STAT_WR && on_bound
                      && write_enable_latch && !write_busy_flag
                      && !hard_now;

  // Array write: whole bytes after the address, outside the protected area
  assign start_arr = cs_rise && op == OP_ARRAY_WR && nbytes == CNT_ARRAY_WR && on_bound
                     && write_enable_latch && !write_busy_flag
                     && !eep_prot_hit({protect_sel_hi, protect_sel_lo},
                                      waddr);

  assign cyc_done = write_busy_flag && tmr == {TMR_W{1'b0}};

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      write_enable_latch <= RST_LATCH;
    end
    else if (cyc_done)
    begin
      write_enable_latch <= 1'b0;
    end
    else if (cs_rise && nbytes == CNT_OP && on_bound && !write_busy_flag)
    begin
      if (op == OP_SET_LATCH)
      begin
        write_enable_latch <= 1'b1;
      end
      else if (op == OP_CLR_LATCH)
      begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-timed write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      write_busy_flag <= RST_BUSY;
      tmr <= {TMR_W{1'b0}};
      cyc_is_stat <= 1'b0;
      pend_stat <= 8'h00;
    end
    else if (start_stat || start_arr)
    begin
      write_busy_flag <= 1'b1;
      tmr <= TMR_W'(PROG_CYCLES_P - 1);
      cyc_is_stat <= start_stat;
      pend_stat <= wdata;
    end
    else if (cyc_done)
    begin
      write_busy_flag <= 1'b0;
    end
    else if (write_busy_flag)
    begin
      tmr <= tmr - TMR_W'(1);
    end
  end

  // Non-volatile bits change only when a status cycle completes
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      status_lock_bit <= RST_LOCK;
      protect_sel_hi <= RST_BP[1];
      protect_sel_lo <= RST_BP[0];
    end
    else if (cyc_done && cyc_is_stat)
    begin
      status_lock_bit <= pend_stat[ST_LOCK];
      protect_sel_hi <= pend_stat[ST_BP_HI];
      protect_sel_lo <= pend_stat[ST_BP_LO];
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      wr_go <= 1'b0;
      wr_addr <= {ADDR_W{1'b0}};
      hard_lock_mode <= 1'b0;
      soft_guard_mode <= 1'b1;
    end
    else
    begin
      wr_go <= start_arr;
      wr_addr <= start_arr ? waddr : wr_addr;
      hard_lock_mode <= hard_now;
      soft_guard_mode <= !hard_now;
    end
  end

  // ----------------------------------------------------------------
  // Check helper: length of the running write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      busy_len <= {TMR_W{1'b0}};
    end
    else if (write_busy_flag)
    begin
      busy_len <= busy_len + TMR_W'(1);
    end
    else
    begin
      busy_len <= {TMR_W{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_latch_only_set: assert property (
    $rose(write_enable_latch) |-> $past(cs_rise && op == OP_SET_LATCH && nbytes == CNT_OP))
    else $error("latch rose without a set command at deselect");

  a_latch_clear_cmd: assert property (
    cs_rise && op == OP_CLR_LATCH && nbytes == CNT_OP && on_bound && !write_busy_flag
    |=> !write_enable_latch)
    else $error("clear command left latch set");

  a_busy_after_start: assert property (
    start_stat |=> write_busy_flag [*8])
    else $error("busy flag not held after status write start");

  a_latch_end_cycle: assert property (
    $fell(write_busy_flag) |-> !write_enable_latch && $past(tmr) == {TMR_W{1'b0}})
    else $error("cycle ended early or left latch set");

  a_reject_no_latch: assert property (
    cs_rise && !write_enable_latch && !write_busy_flag |=> !write_busy_flag && !wr_go)
    else $error("write started with latch clear");

  a_hard_lock_rej: assert property (
    cs_rise && op == OP_STAT_WR && status_lock_bit && !wp_s2 && !write_busy_flag
    |=> !write_busy_flag)
    else $error("status write accepted in hard lock mode");

  a_nv_stable: assert property (
    !($past(write_busy_flag) && !write_busy_flag)
    |-> $stable({status_lock_bit, protect_sel_hi, protect_sel_lo}))
    else $error("protect bits changed outside cycle end");

  a_prot_refuse: assert property (
    cs_rise && op == OP_ARRAY_WR && eep_prot_hit({protect_sel_hi, protect_sel_lo}, waddr)
    |=> !wr_go)
    else $error("write into protected area started");

  a_hard_mode_out: assert property (
    status_lock_bit && !wp_s2 |=> hard_lock_mode)
    else $error("hard lock mode not entered");

  a_soft_mode_out: assert property (
    !status_lock_bit || wp_s2 |=> soft_guard_mode && !hard_lock_mode)
    else $error("hard lock mode held without lock and pin low");

  a_latch_set_cmd: assert property (
    cs_rise && op == OP_SET_LATCH && nbytes == CNT_OP && on_bound && !write_busy_flag
    |=> write_enable_latch)
    else $error("set command left latch clear");

  a_busy_length: assert property (
    $fell(write_busy_flag) |-> busy_len == TMR_W'(PROG_CYCLES_P))
    else $error("write cycle length wrong");

  a_write_needs_latch: assert property (
    $rose(write_busy_flag) |-> $past(write_enable_latch))
    else $error("write cycle started without latch");

  a_wr_go_gate: assert property (
    wr_go |-> $past(write_enable_latch) && !$past(write_busy_flag))
    else $error("array write started without latch or while busy");

  a_wr_addr_free: assert property (
    wr_go |-> !eep_prot_hit({protect_sel_hi, protect_sel_lo}, wr_addr))
    else $error("array write started in protected area");

  a_latch_hold_busy: assert property (
    write_busy_flag && !cyc_done && write_enable_latch
    |=> write_enable_latch)
    else $error("latch dropped before cycle end");

endmodule : eep_cmd

`default_nettype wire

// ### test/eep_spi_master.sv
/*
  Behavioural SPI bus master (mode 0) facing the EEPROM command block.
  Assumes the bench calls frame() from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module eep_spi_master
(
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic oe_seen;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    oe_seen = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame
  // ----------------------------------------------------------------
  // Sclk runs only inside a frame; the gap keeps cs_n high long enough
  task automatic frame(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      mosi = tx[i];
      #6 sclk = 1'b1;
      rx = {rx[62:0], miso};
      oe_seen = oe_seen | (miso_oe_n === 1'b0);
      #6 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    mosi = ~mosi;
    #1000;
  endtask : frame
endmodule : eep_spi_master

`default_nettype wire

// ### test/spi_eeprom_cmd_status_tb.sv
/*
  Self-checking bench for the EEPROM command, status and protect block.
  Assumes eep_pkg and a shortened write cycle of 60 core clocks, long
  enough for a read and a status read to fall inside one write cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_cmd_status_tb;
  import eep_pkg::*;
  localparam int PROG = 60;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wp_n = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe_n, wr_go, hard_lock_mode, soft_guard_mode;
  logic [ADDR_W-1:0] array_addr, wr_addr, wr_last, a;
  logic [7:0] array_rdata, st, d;
  logic [63:0] rx;
  int mismatches = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int cycles = 0;
  integer seed = 32'h0a28;

  always #50 core_clk = ~core_clk;

  function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] ad);
    return ad[7:0] ^ {1'b0, ad[14:8]};
  endfunction : mem_byte

  function automatic logic [7:0] es(input logic lk, input logic [1:0] bp, input logic l, b);
    return {lk, 3'b000, bp, l, b};
  endfunction : es

  assign array_rdata = mem_byte(array_addr);

  eep_cmd #(.PROG_CYCLES_P(PROG)) eep_cmd_i (.core_clk(core_clk), .rstn(rstn),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n), .array_rdata(array_rdata),
    .miso(miso), .miso_oe_n(miso_oe_n), .array_addr(array_addr), .wr_go(wr_go),
    .wr_addr(wr_addr), .hard_lock_mode(hard_lock_mode), .soft_guard_mode(soft_guard_mode));

  eep_spi_master eep_spi_master_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n));

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (wr_go === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= wr_addr;
    end
    if (cycles == 5000)
    begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0t %s: got %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic cmd(input logic [7:0] op);
    eep_spi_master_i.frame(8, {56'h0, op}, rx);
  endtask : cmd

  task automatic stat_rd(input logic [7:0] exp);
    eep_spi_master_i.frame(16, {48'h0, OP_STAT_RD, 8'h00}, rx);
    check(rx[7:0], exp, "status byte");
  endtask : stat_rd

  task automatic cmd_status_write(input int nbits, input logic [7:0] v);
    eep_spi_master_i.frame(nbits, {48'h0, OP_STAT_WR, v} << (nbits - 16), rx);
  endtask : cmd_status_write

  task automatic awr(input logic [ADDR_W-1:0] ad);
    eep_spi_master_i.frame(32, {32'h0, OP_ARRAY_WR, 1'b0, ad, 8'h5A}, rx);
  endtask : awr

  // Master waits for the busy flag to drop before the next command
  task automatic poll(input logic [7:0] exp);
    st = 8'hFF;
    for (int i = 0; i < 10 && st[0] !== 1'b0; i++)
    begin
      eep_spi_master_i.frame(16, {48'h0, OP_STAT_RD, 8'h00}, rx);
      st = rx[7:0];
    end
    check(st, exp, "status after cycle");
  endtask : poll

  task automatic prot(input logic wp, input logic hl);
    @(posedge core_clk);
    wp_n <= wp;
    repeat (5) @(posedge core_clk);
    check({hard_lock_mode, soft_guard_mode}, {hl, ~hl}, "protect mode");
  endtask : prot

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
    stat_rd(8'h00);
    cmd(OP_SET_LATCH);
    eep_spi_master_i.frame(24, {40'h0, OP_STAT_RD, 16'h0}, rx);
    check(rx[15:0], 16'h0202, "repeated status");
    cmd(OP_CLR_LATCH);
    stat_rd(8'h00);
    cmd_status_write(16, 8'h8C);
    stat_rd(8'h00);
    cmd(OP_SET_LATCH);
    d = 8'h8C | (8'h73 & $random(seed));
    cmd_status_write(16, d);
    eep_spi_master_i.frame(48, {16'h0, OP_ARRAY_RD, 40'h0}, rx);
    check(eep_spi_master_i.oe_seen, 1'b0, "read during busy");
    stat_rd(es(1'b0, 2'h0, 1'b1, 1'b1));
    poll(es(1'b1, 2'h3, 1'b0, 1'b0));
    cmd(OP_SET_LATCH);
    awr(15'h0010);
    check(wr_cnt, 0, "write to full protect");
    stat_rd(8'h8E);
    prot(1'b0, 1'b1);
    cmd_status_write(16, 8'h04);
    stat_rd(8'h8E);
    prot(1'b1, 1'b0);
    cmd_status_write(17, 8'h04);
    stat_rd(8'h8E);
    cmd_status_write(16, 8'h04);
    poll(8'h04);
    cmd(OP_SET_LATCH);
    awr(15'h6000);
    check(wr_cnt, 0, "write to quarter");
    awr(15'h5FFF);
    check({wr_cnt[7:0], wr_last}, {8'h01, 15'h5FFF}, "accepted write");
    poll(8'h04);
    d = $random(seed);
    if (d >= 8'h01 && d <= 8'h06)
      d = 8'hA5;
    eep_spi_master_i.frame(16, {48'h0, d, 8'h00}, rx);
    check(eep_spi_master_i.oe_seen, 1'b0, "unknown opcode output");
    stat_rd(8'h04);
    prot(1'b0, 1'b0);
    cmd(OP_SET_LATCH);
    cmd_status_write(16, 8'h80);
    poll(8'h80);
    prot(1'b0, 1'b1);
    prot(1'b1, 1'b0);
    eep_spi_master_i.frame(48, {16'h0, OP_ARRAY_RD, 16'hFFFE, 24'h0}, rx);
    check(rx[23:0], {mem_byte(15'h7FFE), mem_byte(15'h7FFF), mem_byte(15'h0)}, "wrap");
    a = $random(seed);
    eep_spi_master_i.frame(40, {24'h0, OP_ARRAY_RD, 1'b0, a, 16'h0}, rx);
    check(rx[15:0], {mem_byte(a), mem_byte(a + 15'h1)}, "sequential read");
    summarize();
  end
endmodule : spi_eeprom_cmd_status_tb

`default_nettype wire
